// File: pkg/pse_class_pkg.sv
package pse_class_pkg;
  // ****************************************
  // register map and strap reset values
  // ****************************************
  localparam logic [7:0] ADDR_PORT_MODE = 8'h12;
  localparam logic [7:0] ADDR_DET_CLASS_EN = 8'h14;
  localparam logic [7:0] ADDR_PAIR_CFG = 8'h29;
  localparam logic [7:0] ADDR_CLASS_STATUS = 8'h2A;
  localparam logic [7:0] REG_ALL_OFF = 8'h00;
  localparam logic [7:0] REG_ALL_ON = 8'hFF;
  localparam logic [7:0] PAIR_CFG_OFF = 8'h88;
  localparam logic [7:0] PAIR_CFG_C4 = 8'hBB;
  localparam logic [7:0] PAIR_CFG_C5 = 8'hCC;
  localparam logic [7:0] PAIR_CFG_C6 = 8'hDD;
  localparam logic [7:0] PAIR_CFG_C7 = 8'hEE;
  localparam logic [7:0] PAIR_CFG_C8 = 8'hFF;
  // measured strap resistor codes: open, 14.3k, 11.0k, 8.45k, 6.49k, 1k
  localparam logic [2:0] STRAP_OPEN = 3'h0;
  localparam logic [2:0] STRAP_14K3 = 3'h1;
  localparam logic [2:0] STRAP_11K0 = 3'h2;
  localparam logic [2:0] STRAP_8K45 = 3'h3;
  localparam logic [2:0] STRAP_6K49 = 3'h4;
  localparam logic [2:0] STRAP_1K0 = 3'h5;
  // ****************************************
  // field layout
  // ****************************************
  localparam int MODE_LSB = 0;
  localparam logic [1:0] MODE_AUTO = 2'h3;
  localparam int DET_EN_BIT = 0;
  localparam int CLS_EN_BIT = 4;
  localparam logic [3:0] CFG_NIB_BASE = 4'h7;
  localparam logic [3:0] CFG_NIB_MIN = 4'hB;
  localparam logic [3:0] TYPE4_CLASS = 4'h7;
  // ****************************************
  // signatures and allocations (class numbers)
  // ****************************************
  localparam logic [3:0] SIG_TOP = 4'h4;
  localparam logic [3:0] ALLOC_13W = 4'h3;
  localparam logic [3:0] ALLOC_25W = 4'h4;
  localparam logic [3:0] ALLOC_51W = 4'h6;
  localparam logic [3:0] DS_CLASS5 = 4'h5;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLK_MHZ = 25;
  localparam int MARK_PAUSE_NS = 6000;
  localparam int CLASS_RESET_HOLD_NS = 15000;
  localparam int MARK_CYC = (MARK_PAUSE_NS * CLK_MHZ + 999) / 1000;
  localparam int RESET_CYC = (CLASS_RESET_HOLD_NS * CLK_MHZ + 999) / 1000;
endpackage

// File: pkg/class_phase_if.sv
`timescale 1ns/1ps
interface class_phase_if;
  logic go_event; // start one class event
  logic go_reset; // start one class reset
  logic first; // event opens a sequence, no mark before it
  logic meas_done; // signature measured, end event
  logic event_on;
  logic mark_on;
  logic reset_on;
  logic done; // phase finished pulse
  modport ctrl (output go_event, go_reset, first, meas_done, input event_on, mark_on, reset_on, done);
  modport seq (input go_event, go_reset, first, meas_done, output event_on, mark_on, reset_on, done);
endinterface

// File: hdl/class_phase_timer.sv
`timescale 1ns/1ps
module class_phase_timer
  import pse_class_pkg::*;
#(
  parameter int MARK_N = MARK_CYC,
  parameter int RESET_N = RESET_CYC
) (
  input wire logic i_ref_clk, // 25 MHz clock
  input wire logic i_rst, // sync reset, high
  class_phase_if.seq cp // phase requests and pairset drive
);
  typedef enum {PH_IDLE, PH_MARK, PH_EVENT, PH_RESET} phase_e;
  typedef struct packed {
    phase_e ph;
    logic [15:0] cnt;
    logic done;
  } tmr_s;
  tmr_s q_r, q_nxt;

  // ****************************************
  // phase sequencing
  // ****************************************
  // one request at a time; the controller only asks while idle
  always_comb begin
    q_nxt = q_r;
    q_nxt.done = 1'b0;
    case (q_r.ph)
      PH_IDLE: begin
        // R15: reset hold
        if (cp.go_reset) begin
          q_nxt.ph = PH_RESET;
          q_nxt.cnt = 16'(RESET_N - 1);
        end else if (cp.go_event) begin
          q_nxt.ph = cp.first ? PH_EVENT : PH_MARK;
          q_nxt.cnt = 16'(MARK_N - 1);
        end
      end
      PH_MARK: begin
        // R23: mark pause
        if (q_r.cnt == 16'h0000) q_nxt.ph = PH_EVENT;
        else q_nxt.cnt = q_r.cnt - 16'h0001;
      end
      PH_EVENT: begin
        if (cp.meas_done) begin
          q_nxt.ph = PH_IDLE;
          q_nxt.done = 1'b1;
        end
      end
      PH_RESET: begin
        if (q_r.cnt == 16'h0000) begin
          q_nxt.ph = PH_IDLE;
          q_nxt.done = 1'b1;
        end else q_nxt.cnt = q_r.cnt - 16'h0001;
      end
      default: q_nxt.ph = PH_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) q_r <= '{ph: PH_IDLE, cnt: 16'h0000, done: 1'b0};
    else q_r <= q_nxt;
  end

  assign cp.event_on = (q_r.ph == PH_EVENT);
  assign cp.mark_on = (q_r.ph == PH_MARK);
  assign cp.reset_on = (q_r.ph == PH_RESET);
  assign cp.done = q_r.done;

  // ****************************************
  // checks
  // ****************************************
  logic [15:0] run_r; // length of current reset or mark phase
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) run_r <= 16'h0000;
    else if (cp.reset_on || cp.mark_on) run_r <= run_r + 16'h0001;
    else run_r <= 16'h0000;
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  reset_hold_len_a: assert property ($fell(cp.reset_on) |-> run_r == 16'(RESET_N)) // R15
    else $error("class reset hold too short or long");
  mark_len_a: assert property ($fell(cp.mark_on) |-> cp.event_on && run_r == 16'(MARK_N)) // R23
    else $error("mark pause wrong length or not followed by event");
  event_after_mark_a: assert property ((q_r.ph == PH_IDLE && cp.go_event && !cp.first) |=> cp.mark_on) // R23
    else $error("next event issued without mark pause");
  reset_seen_c: cover property ($fell(cp.reset_on));
endmodule // class_phase_timer

// File: hdl/pse_multi_event_classifier.sv
`timescale 1ns/1ps
// Overview of operation
// R1: one event for single-signature class 0-3
// R2: limited power: one event demotes 13W
// R3: three events for class 4 request
// R4: signature 4 throughout means class 4
// R5: limited: stop at three, 25.5W
// R6: four events for class 5/6
// R7: limited: four events demote 51W
// R8: five events only for Type 4
// R9: dual-signature pairsets classified independently
// R10: three events for dual-signature pairset
// R11: class reset then one event, 13W
// R12: dual class 5 limited: three events
// R13: dual class 5 Type 4: four events
// R14: four-pair eligibility conditions
// R15: class reset holds below 2.8V minimum
// R16: auto mode uses four-pair result
// R17: host may force four-pair power later
// R18: first two signatures must match
// R19: over-limit signature is invalid
// R20: auto mode classifies and powers alone
// R21: strap sampled once after reset
// R22: strap decodes to register presets
// R23: mark pause between class events
module pse_multi_event_classifier
  import pse_class_pkg::*;
(
  input wire logic i_ref_clk, // 25 MHz clock
  input wire logic i_rst, // sync reset, high
  input wire logic i_reg_wr, // register write strobe
  input wire logic i_reg_rd, // register read strobe
  input wire logic [7:0] i_reg_addr, // register offset
  input wire logic [7:0] i_reg_wdata, // write data
  output logic [7:0] o_reg_rdata, // read data, next cycle
  input wire logic [2:0] i_strap_code, // measured strap resistor code (pin)
  input wire logic i_det_done, // detection finished pulse
  input wire logic [1:0] i_det_valid, // valid signature per pairset
  input wire logic i_dual_signature, // PD is dual-signature
  input wire logic i_redetect_ok, // unpowered pairset still detects
  input wire logic i_pd_gone, // port turned off elsewhere
  input wire logic [3:0] i_budget_class, // highest class power allows
  input wire logic [1:0] i_meas_done, // class measurement ready
  input wire logic [7:0] i_meas_sig, // signature per pairset, 4 bits each
  input wire logic [1:0] i_meas_over, // above class current limit
  input wire logic i_host_4p, // host four-pair command pulse
  output logic [1:0] o_class_event, // drive class voltage
  output logic [1:0] o_mark, // drive mark voltage
  output logic [1:0] o_class_reset, // hold pairset low
  output logic [1:0] o_power_on, // power channel request
  output logic [7:0] o_alloc_class, // allocated class per pairset
  output logic [1:0] o_invalid, // invalid classification result
  output logic o_four_pair_identification, // four-pair eligible
  output logic o_done // classification finished
);
  typedef enum {ST_STRAP, ST_IDLE, ST_CLASS, ST_POWER} port_e;
  typedef struct packed {
    logic [3:0] s1; // first signature
    logic [3:0] s3; // third signature
    logic [2:0] n; // events done
    logic [3:0] req; // requested class
    logic [3:0] alloc;
    logic active, in_rst, was_rst, type34, done, invalid, go_ev, go_rst, first;
  } pair_s;
  typedef struct packed {
    port_e st;
    logic [2:0] sy1, sy2, sy3;
    logic [7:0] mode, en, cfg, rdata;
    logic dual;
    logic [1:0] dv, pwr;
    logic fourp, host4p;
    logic [1:0] warm; // strap settle count
    pair_s [1:0] pr;
  } top_s;
  top_s q_r, q_nxt;
  logic [1:0] ev_on, mk_on, rs_on, ph_done;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [3:0] cfg_class(input logic [3:0] nib);
    return (nib >= CFG_NIB_MIN) ? nib - CFG_NIB_BASE : 4'h0;
  endfunction
  // a pairset is finished unless it asked for another event or a class reset
  function automatic pair_s decide(input pair_s p, input logic ss, input logic t4, input logic [3:0] mx,
                                   input logic [3:0] sg, input logic ov);
    pair_s r;
    logic [2:0] k;
    r = p;
    k = p.n + 3'd1;
    r.n = k;
    r.first = 1'b0;
    // R19: over limit
    if (ov || sg > SIG_TOP) r.invalid = 1'b1;
    else begin
      case (k)
        3'd1: begin
          r.s1 = sg;
          // R11: demoted after reset
          if (p.was_rst) r.alloc = ALLOC_13W;
          // R1: single event
          else if (ss && sg < SIG_TOP) r.alloc = sg;
          // R2: demote to 13W
          else if (ss && mx < SIG_TOP) r.alloc = ALLOC_13W;
          // R3: class 4 request, more events
          else r.go_ev = 1'b1;
        end
        3'd2: begin
          // R18: pair must match
          if (sg != p.s1) r.invalid = 1'b1;
          else r.go_ev = 1'b1;
        end
        3'd3: begin
          r.s3 = sg;
          r.type34 = (sg != p.s1);
          if (ss) begin
            r.req = (sg == SIG_TOP) ? SIG_TOP : 4'd5 + sg;
            r.alloc = ALLOC_25W;
            // R4: class 4 / R5: demote / R6 R7: fourth event
            r.go_ev = (sg != SIG_TOP && mx > SIG_TOP);
          end else if (p.s1 < SIG_TOP) begin
            // R10: dual class 0-3, R18: legal sequence
            r.alloc = sg;
            r.invalid = (sg != p.s1);
          end else if (sg != SIG_TOP && sg != ALLOC_13W) r.invalid = 1'b1;
          else begin
            r.req = (sg == SIG_TOP) ? SIG_TOP : DS_CLASS5;
            r.alloc = ALLOC_25W;
            // R11: reset then single event
            r.go_rst = (mx < SIG_TOP);
            r.in_rst = r.go_rst;
            // R13: fourth event, R12 otherwise
            r.go_ev = !r.go_rst && r.req == DS_CLASS5 && t4 && mx >= DS_CLASS5;
          end
        end
        3'd4: begin
          if (sg != p.s3) r.invalid = 1'b1;
          else if (!ss) r.alloc = DS_CLASS5;
          else if (p.req < TYPE4_CLASS) r.alloc = p.req;
          // R8: fifth event
          else if (t4 && mx >= TYPE4_CLASS) r.go_ev = 1'b1;
          else r.alloc = ALLOC_51W;
        end
        3'd5: begin
          r.invalid = (sg != p.s3);
          r.alloc = p.req;
        end
        default: r.invalid = 1'b1;
      endcase
    end
    r.done = !(r.go_ev || r.go_rst);
    return r;
  endfunction
  // ****************************************
  // per-pairset event timers
  // ****************************************
  // R9: each pairset has its own sequencer
  for (genvar g = 0; g < 2; g++) begin : g_seq
    class_phase_if cp ();
    assign cp.go_event = q_r.pr[g].go_ev;
    assign cp.go_reset = q_r.pr[g].go_rst;
    assign cp.first = q_r.pr[g].first;
    assign cp.meas_done = i_meas_done[g];
    assign ev_on[g] = cp.event_on;
    assign mk_on[g] = cp.mark_on;
    assign rs_on[g] = cp.reset_on;
    assign ph_done[g] = cp.done;
    class_phase_timer u_timer (
      .i_ref_clk(i_ref_clk),
      .i_rst(i_rst),
      .cp(cp)
    );
  end

  // ****************************************
  // port control
  // ****************************************
  logic auto_on, type4, all_fin;
  logic [3:0] mx;
  assign auto_on = q_r.mode[MODE_LSB +: 2] == MODE_AUTO && q_r.en[DET_EN_BIT] && q_r.en[CLS_EN_BIT];
  assign type4 = cfg_class(q_r.cfg[3:0]) >= TYPE4_CLASS;
  assign mx = (cfg_class(q_r.cfg[3:0]) < i_budget_class) ? cfg_class(q_r.cfg[3:0]) : i_budget_class;
  assign all_fin = (!q_r.pr[0].active || q_r.pr[0].done) && (!q_r.pr[1].active || q_r.pr[1].done);
  // main sequencing; register writes are blocked until the strap has loaded
  always_comb begin
    q_nxt = q_r;
    q_nxt.sy1 = i_strap_code;
    q_nxt.sy2 = q_r.sy1;
    q_nxt.sy3 = q_r.sy2;
    for (int i = 0; i < 2; i++) begin
      q_nxt.pr[i].go_ev = 1'b0;
      q_nxt.pr[i].go_rst = 1'b0;
    end
    case (q_r.st)
      ST_STRAP: begin
        // R21: one-time sample
        // the stages hold reset zeros at first, which would read as an open strap
        if (q_r.warm != 2'd3) q_nxt.warm = q_r.warm + 2'd1;
        else if (q_r.sy2 == q_r.sy3) begin
          q_nxt.st = ST_IDLE;
          // R22: strap presets
          q_nxt.mode = (q_r.sy3 == STRAP_OPEN) ? REG_ALL_OFF : REG_ALL_ON;
          q_nxt.en = q_nxt.mode;
          case (q_r.sy3)
            STRAP_14K3: q_nxt.cfg = PAIR_CFG_C4;
            STRAP_11K0: q_nxt.cfg = PAIR_CFG_C5;
            STRAP_8K45: q_nxt.cfg = PAIR_CFG_C6;
            STRAP_6K49: q_nxt.cfg = PAIR_CFG_C7;
            STRAP_1K0: q_nxt.cfg = PAIR_CFG_C8;
            default: begin
              q_nxt.cfg = PAIR_CFG_OFF;
              q_nxt.mode = REG_ALL_OFF;
              q_nxt.en = REG_ALL_OFF;
            end
          endcase
        end
      end
      ST_IDLE: begin
        q_nxt.pwr = 2'b00;
        q_nxt.fourp = 1'b0;
        q_nxt.host4p = 1'b0;
        // R20: start without host
        if (i_det_done && auto_on && |i_det_valid) begin
          q_nxt.st = ST_CLASS;
          q_nxt.dual = i_dual_signature;
          q_nxt.dv = i_det_valid;
          for (int i = 0; i < 2; i++) begin
            q_nxt.pr[i] = '0;
            q_nxt.pr[i].active = i_det_valid[i] && (i == 0 || i_dual_signature);
            q_nxt.pr[i].go_ev = q_nxt.pr[i].active;
            q_nxt.pr[i].first = 1'b1;
          end
        end
      end
      ST_CLASS: begin
        for (int i = 0; i < 2; i++) begin
          if (q_r.pr[i].active && !q_r.pr[i].done) begin
            if (ph_done[i] && q_r.pr[i].in_rst && !q_r.pr[i].go_rst) begin // not the event's own done
              // R11: restart after reset
              q_nxt.pr[i].in_rst = 1'b0;
              q_nxt.pr[i].was_rst = 1'b1;
              q_nxt.pr[i].n = 3'd0;
              q_nxt.pr[i].first = 1'b1;
              q_nxt.pr[i].go_ev = 1'b1;
            end else if (i_meas_done[i] && ev_on[i]) begin
              q_nxt.pr[i] = decide(q_r.pr[i], !q_r.dual, type4, mx, i_meas_sig[i*4 +: 4], i_meas_over[i]);
            end
          end
        end
        if (all_fin) begin
          q_nxt.st = ST_POWER;
          // R14: four-pair eligibility
          q_nxt.fourp = &q_r.dv && (!q_r.dual || q_r.pr[0].type34 || q_r.pr[1].type34 || i_redetect_ok);
          // R16: channel count from result
          if (!q_r.dual) q_nxt.pwr = q_r.pr[0].invalid ? 2'b00 : (q_nxt.fourp ? 2'b11 : 2'b01);
          else q_nxt.pwr = {q_r.pr[1].active && !q_r.pr[1].invalid, q_r.pr[0].active && !q_r.pr[0].invalid};
        end
      end
      ST_POWER: begin
        // R17: host four-pair command
        if (i_host_4p && q_r.pwr != 2'b00) begin
          q_nxt.pwr = 2'b11;
          q_nxt.host4p = 1'b1;
        end
        if (i_pd_gone || !auto_on) q_nxt.st = ST_IDLE;
      end
      default: q_nxt.st = ST_IDLE;
    endcase
    // register writes and registered read data
    if (i_reg_wr && q_r.st != ST_STRAP) begin
      case (i_reg_addr)
        ADDR_PORT_MODE: q_nxt.mode = i_reg_wdata;
        ADDR_DET_CLASS_EN: q_nxt.en = i_reg_wdata;
        ADDR_PAIR_CFG: q_nxt.cfg = i_reg_wdata;
        default: ;
      endcase
    end
    if (i_reg_rd) begin
      case (i_reg_addr)
        ADDR_PORT_MODE: q_nxt.rdata = q_r.mode;
        ADDR_DET_CLASS_EN: q_nxt.rdata = q_r.en;
        ADDR_PAIR_CFG: q_nxt.rdata = q_r.cfg;
        ADDR_CLASS_STATUS: q_nxt.rdata = {q_r.st == ST_POWER, q_r.fourp, q_r.pr[1].invalid, q_r.pr[0].invalid,
                                          q_r.pwr, q_r.host4p, q_r.dual};
        default: q_nxt.rdata = 8'h00;
      endcase
    end
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      q_r <= '0;
      q_r.st <= ST_STRAP;
    end else q_r <= q_nxt;
  end
  // ****************************************
  // outputs
  // ****************************************
  assign o_reg_rdata = q_r.rdata;
  assign o_class_event = ev_on;
  assign o_mark = mk_on;
  assign o_class_reset = rs_on;
  assign o_power_on = q_r.pwr;
  assign o_alloc_class = {q_r.pr[1].alloc, q_r.pr[0].alloc};
  assign o_invalid = {q_r.pr[1].invalid, q_r.pr[0].invalid};
  assign o_four_pair_identification = q_r.fourp;
  assign o_done = (q_r.st == ST_POWER);

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  one_event_cap_a: assert property ((q_r.pr[0].done && !q_r.pr[0].invalid && !q_r.dual && q_r.pr[0].n == 3'd1)
    |-> q_r.pr[0].alloc <= ALLOC_13W) // R1
    else $error("single event gave more than 13W");
  class4_all_four_a: assert property ((q_r.pr[0].done && !q_r.dual && !q_r.pr[0].invalid && q_r.pr[0].n == 3'd3
    && q_r.pr[0].s3 == SIG_TOP) |-> q_r.pr[0].alloc == ALLOC_25W) // R4
    else $error("signature 4 on all events not class 4");
  five_only_t4_a: assert property (q_r.pr[0].n == 3'd5 |-> type4) // R8
    else $error("fifth event outside Type 4");
  first_pair_a: assert property ((q_r.st == ST_CLASS && i_meas_done[0] && ev_on[0] && q_r.pr[0].n == 3'd1
    && !q_r.pr[0].invalid && !i_meas_over[0] && i_meas_sig[3:0] != q_r.pr[0].s1) |=> o_invalid[0]) // R18
    else $error("mismatched first two signatures not flagged");
  over_limit_a: assert property ((q_r.st == ST_CLASS && q_r.pr[0].active && !q_r.pr[0].done && !q_r.pr[0].in_rst
    && i_meas_done[0] && ev_on[0] && i_meas_over[0]) |=> o_invalid[0]) // R19
    else $error("over limit signature not flagged");
  four_pair_gate_a: assert property ((o_power_on == 2'b11 && !q_r.dual && !q_r.host4p)
    |-> o_four_pair_identification && q_r.dv == 2'b11) // R14
    else $error("four-pair power without eligibility");
  strap_open_a: assert property ((q_r.st == ST_STRAP && q_r.warm == 2'd3 && q_r.sy2 == q_r.sy3 && q_r.sy3 == STRAP_OPEN)
    |=> q_r.cfg == PAIR_CFG_OFF && q_r.mode == REG_ALL_OFF && q_r.st == ST_IDLE) // R22
    else $error("open strap preset wrong");
  auto_start_a: assert property ((q_r.st == ST_IDLE && i_det_done && auto_on && i_det_valid[0])
    |-> ##3 o_class_event[0]) // R20
    else $error("auto mode did not start classification");
  single_event_c: cover property (q_r.st == ST_CLASS && all_fin && q_r.pr[0].n == 3'd1);
  five_event_c: cover property (q_r.pr[0].done && q_r.pr[0].n == 3'd5);
  class_reset_c: cover property ($rose(o_class_reset[1]));
  host_4p_c: cover property ($rose(q_r.host4p));
endmodule // pse_multi_event_classifier

// File: verification/pd_model.sv
`timescale 1ns/1ps
module pd_model (
  input wire logic i_ref_clk, // clock
  input wire logic i_clr, // clear counters
  input wire logic [19:0] i_sig_a, // signature per event, A
  input wire logic [19:0] i_sig_b, // signature per event, B
  input wire logic [1:0] i_over, // over current limit
  input wire logic [1:0] i_event, // class voltage seen
  input wire logic [1:0] i_mark, // mark voltage seen
  input wire logic [1:0] i_hold, // class reset seen
  output logic [1:0] o_done, // measurement ready
  output logic [7:0] o_sig, // signature per pairset
  output logic [1:0] o_over, // over limit flags
  output logic [5:0] o_events, // events, 3 bits each
  output logic [5:0] o_marks, // mark rises, 3 bits each
  output logic [1:0] o_resets, // class reset seen
  output logic [9:0] o_hold_len // reset hold cycles, B
);
  logic [1:0] w [2];
  logic [2:0] idx [2];
  logic [1:0] mk_q;
  // ****
  // pd answer: three cycles into each event; sig lines toggle when idle so stale values never match
  // ****
  always_ff @(posedge i_ref_clk) begin
    mk_q <= i_mark;
    for (int p = 0; p < 2; p++) begin
      o_done[p] <= 1'b0;
      o_over[p] <= 1'b0;
      o_sig[4*p+:4] <= ~o_sig[4*p+:4];
      if (i_clr) begin
        w[p] <= 2'h0;
        idx[p] <= 3'h0;
        o_events[3*p+:3] <= 3'h0;
        o_marks[3*p+:3] <= 3'h0;
        o_resets[p] <= 1'b0;
        o_sig[4*p+:4] <= 4'h5;
      end else if (!i_event[p]) begin
        w[p] <= 2'h0;
      end else if (w[p] != 2'h3) begin
        w[p] <= w[p] + 2'h1;
        if (w[p] == 2'h2) begin
          o_done[p] <= 1'b1;
          o_over[p] <= i_over[p];
          o_sig[4*p+:4] <= p ? i_sig_b[4*idx[p]+:4] : i_sig_a[4*idx[p]+:4];
          o_events[3*p+:3] <= o_events[3*p+:3] + 3'h1;
          if (idx[p] != 3'h4) idx[p] <= idx[p] + 3'h1;
        end
      end
      if (i_mark[p] && !mk_q[p]) o_marks[3*p+:3] <= o_marks[3*p+:3] + 3'h1;
      if (i_hold[p]) idx[p] <= 3'h0;
      if (i_hold[p]) o_resets[p] <= 1'b1;
    end
    o_hold_len <= i_hold[1] ? o_hold_len + 10'h1 : (i_clr ? 10'h0 : o_hold_len);
  end
endmodule // pd_model

// File: verification/pse_multi_event_classifier_tb.sv
`timescale 1ns/1ps
module pse_multi_event_classifier_tb;
  import pse_class_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, det_done = 0, dual = 0, gone = 0, h4p = 0, clr = 0, redet = 0, fourp, done;
  logic [7:0] addr = 0, wdata = 0, rdata, alloc, msig, rv;
  logic [2:0] strap = 3'h5;
  logic [1:0] dv = 0, over = 0, mdone, mover, ev, mk, hold, pwr, inv, rsn;
  logic [3:0] budget = 4'h8;
  logic [19:0] sa = 0, sb = 0;
  logic [5:0] evn, mkn;
  logic [9:0] hlen;
  int err_total = 0, num_checks = 0, cyc = 0;
  pse_multi_event_classifier uut (.i_ref_clk(clk), .i_rst(rst), .i_reg_wr(wr), .i_reg_rd(rd),
    .i_reg_addr(addr), .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_strap_code(strap),
    .i_det_done(det_done), .i_det_valid(dv), .i_dual_signature(dual), .i_redetect_ok(redet),
    .i_pd_gone(gone), .i_budget_class(budget), .i_meas_done(mdone), .i_meas_sig(msig),
    .i_meas_over(mover), .i_host_4p(h4p), .o_class_event(ev), .o_mark(mk), .o_class_reset(hold),
    .o_power_on(pwr), .o_alloc_class(alloc), .o_invalid(inv), .o_four_pair_identification(fourp),
    .o_done(done));
  pd_model pd (.i_ref_clk(clk), .i_clr(clr), .i_sig_a(sa), .i_sig_b(sb), .i_over(over), .i_event(ev),
    .i_mark(mk), .i_hold(hold), .o_done(mdone), .o_sig(msig), .o_over(mover), .o_events(evn),
    .o_marks(mkn), .o_resets(rsn), .o_hold_len(hlen));
  // 25 MHz clock
  initial forever #20 clk = ~clk;
  // ****
  // shared tasks
  // ****
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    $display("checks=%0d mismatches=%0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    addr = a;
    wdata = d;
    wr = 1;
    @(negedge clk);
    wr = 0;
  endtask
  // read data is a register: settled by the following falling edge
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    addr = a;
    rd = 1;
    @(negedge clk);
    rd = 0;
    d = rdata;
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk);
    s = 1;
    @(negedge clk);
    s = 0;
  endtask
  // one detection and classification run; ea of 7 skips counts and allocation
  task automatic run_case(input logic d, input logic [1:0] v, input logic [3:0] b, input logic [19:0] a,
    input logic [19:0] bb, input logic [1:0] ov, input logic [2:0] ea, input logic [2:0] eb,
    input logic [7:0] al, input logic [1:0] iv, input logic [1:0] pw);
    int n;
    pulse(gone);
    pulse(clr);
    dual = d;
    dv = v;
    budget = b;
    sa = a;
    sb = bb;
    over = ov;
    pulse(det_done);
    n = 0;
    while (done !== 1'b1 && n < 4000) begin
      @(negedge clk);
      n++;
    end
    check(done, 1'b1);
    @(negedge clk);
    check(inv, iv);
    check(pwr, pw);
    if (ea != 3'h7) begin
      check({d ? alloc[7:4] : 4'h0, alloc[3:0]}, al);
      check({d ? evn[5:3] : 3'h0, evn[2:0]}, {eb, ea});
      if (!d) check(mkn[2:0], ea - 3'h1);
    end
    $display("case finished at %0t", $time);
  endtask
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      err_total++;
      close_out();
    end
  end
  // ****
  // test sequence
  // ****
  initial begin
    for (int c = 0; c < 6; c++) begin
      strap = 3'(c);
      rst = 1;
      repeat (20) @(negedge clk);
      rst = 0;
      repeat (8) @(negedge clk);
      reg_rd(ADDR_PORT_MODE, rv);
      check(rv, c == 0 ? REG_ALL_OFF : REG_ALL_ON);
      reg_rd(ADDR_DET_CLASS_EN, rv);
      check(rv, c == 0 ? REG_ALL_OFF : REG_ALL_ON);
      reg_rd(ADDR_PAIR_CFG, rv);
      check(rv, c == 0 ? PAIR_CFG_OFF : {2{4'hA + 4'(c)}});
      $display("strap case %0d finished", c);
    end
    strap = 3'h0;
    reg_rd(8'h33, rv);
    check(rv, 8'h00);
    reg_wr(ADDR_DET_CLASS_EN, 8'h11);
    reg_rd(ADDR_DET_CLASS_EN, rv);
    check(rv, 8'h11);
    reg_rd(ADDR_PAIR_CFG, rv);
    check(rv, PAIR_CFG_C8);
    run_case(0, 3, 8, 20'h22222, 0, 0, 1, 0, 8'h02, 0, 3);
    run_case(0, 3, 8, 20'h00000, 0, 0, 1, 0, 8'h00, 0, 3);
    run_case(0, 3, 8, 20'h33333, 0, 0, 1, 0, 8'h03, 0, 3);
    run_case(0, 3, 3, 20'h44444, 0, 0, 1, 0, 8'h03, 0, 3);
    run_case(0, 3, 8, 20'h44444, 0, 0, 3, 0, 8'h04, 0, 3);
    check(fourp, 1'b1);
    run_case(0, 3, 4, 20'h00044, 0, 0, 3, 0, 8'h04, 0, 3);
    run_case(0, 3, 8, 20'h11144, 0, 0, 4, 0, 8'h06, 0, 3);
    run_case(0, 3, 6, 20'h33344, 0, 0, 4, 0, 8'h06, 0, 3);
    run_case(0, 3, 8, 20'h22244, 0, 0, 5, 0, 8'h07, 0, 3);
    run_case(0, 3, 8, 20'h33334, 0, 0, 7, 0, 8'h00, 1, 0);
    run_case(0, 3, 8, 20'h22222, 0, 1, 7, 0, 8'h00, 1, 0);
    redet = 1'b1;
    run_case(1, 3, 8, 20'h11111, 20'h44444, 0, 3, 3, 8'h41, 0, 3);
    check(fourp, 1'b1);
    redet = 1'b0;
    run_case(1, 3, 3, 20'h11111, 20'h44444, 0, 3, 4, 8'h31, 0, 3);
    check(fourp, 1'b0);
    check(rsn, 2'h2);
    check(hlen >= 10'(RESET_CYC), 1'b1);
    run_case(1, 3, 4, 20'h11111, 20'h33344, 0, 3, 3, 8'h41, 0, 3);
    run_case(1, 3, 8, 20'h11111, 20'h33344, 0, 3, 4, 8'h51, 0, 3);
    run_case(0, 1, 8, 20'h22222, 0, 0, 1, 0, 8'h02, 0, 1);
    check(fourp, 1'b0);
    pulse(h4p);
    @(negedge clk);
    check(pwr, 2'h3);
    reg_wr(ADDR_PORT_MODE, REG_ALL_OFF);
    pulse(gone);
    pulse(clr);
    pulse(det_done);
    repeat (20) @(negedge clk);
    check({done, evn}, 0);
    $display("register and mode tests finished");
    close_out();
  end
endmodule // pse_multi_event_classifier_tb
